// ==== rtl/fsc_param_cfg_check.sv ====
// Parameter-set and configuration-check handler of a fieldbus slave station
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ps
`include "fsc_defines.svh"
module fsc_param_cfg_check
  import fsc_pkg::*;
#(
  parameter int          MAX_MODS    = 8,
  parameter logic [15:0] OWN_ID      = 16'h5A3C, // Arbitrary identity value
  parameter int          WD_UNIT_CYC = `FSC_WD_UNIT_CYC,
  parameter int          BIT_CYC     = `FSC_BIT_CYC
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire fsc_rx_t     rx,
  output logic             rx_ready,
  output fsc_ack_t         ack,
  output fsc_state_t       station_state,
  output logic             diag_cfg_fault,
  output logic             diag_prm_fault,
  output logic             locked,
  output logic      [7:0]  group_mask,
  output logic      [7:0]  responder_delay,
  output logic      [15:0] watchdog_product
);

  localparam int AW = (MAX_MODS > 1) ? $clog2(MAX_MODS) : 1;

  if (MAX_MODS < 1 || MAX_MODS > 31) begin : g_bad_mods
    $error("fsc_param_cfg_check: MAX_MODS out of range");
  end
  if (WD_UNIT_CYC < 1 || WD_UNIT_CYC > (1 << 20)) begin : g_bad_wd
    $error("fsc_param_cfg_check: WD_UNIT_CYC out of range");
  end
  if (BIT_CYC < 1 || BIT_CYC > 256) begin : g_bad_bit
    $error("fsc_param_cfg_check: BIT_CYC out of range");
  end

  typedef struct packed {
    logic            enable;
    logic [4:0]      mod_cnt;
    fsc_state_t      st;
    logic            open;
    logic [5:0]      cnt;
    logic [6:0][7:0] b;
    logic            cmp_v;
    logic            cmp_last;
    logic [7:0]      cmp_byte;
    logic [5:0]      cmp_idx;
    logic            mis;
    logic [8:0]      acc;
    logic [8:0]      iolen;
    logic            prm_end;
    logic            busy;
    logic            ok;
    logic [7:0]      dly;
    logic            ack_v;
    logic            ack_ok;
    logic            ack_cfg;
    logic [7:0]      f1;
    logic [7:0]      f2;
    logic [7:0]      delay;
    logic [7:0]      group;
    logic [5:0]      mode;
    logic            locked;
    logic            cfg_fault;
    logic            prm_fault;
    logic [15:0]     wdp;
    logic [19:0]     wd_div;
    logic [15:0]     wd_cnt;
    logic [7:0]      bit_div;
    logic [31:0]     prdata;
  } fsc_regs_t;

  fsc_regs_t r_reg;
  fsc_regs_t r_next;

  function automatic logic addr_known(input logic [11:0] a);
    case (a)
      `FSC_OFF_CTRL, `FSC_OFF_STATUS, `FSC_OFF_PARAM, `FSC_OFF_WDPROD,
      `FSC_OFF_MODCNT, `FSC_OFF_CFGWR, `FSC_OFF_IOLEN: addr_known = 1'b1;
      default: addr_known = 1'b0;
    endcase
  endfunction : addr_known

  // Units of data named by one identifier byte
  function automatic logic [8:0] id_units(input logic [7:0] id);
    id_units = {5'h00, id[3:0]} + 9'h001;
  endfunction : id_units

  function automatic logic [15:0] wd_mult(input logic [7:0] a, input logic [7:0] b);
    wd_mult = {8'h00, a} * {8'h00, b};
  endfunction : wd_mult

  logic            apb_wr;
  logic            mem_we;
  logic [AW-1:0]   mem_raddr;
  logic [7:0]      mem_rdata;
  logic            rx_take;
  logic [5:0]      rx_idx;
  logic [15:0]     prm_id;
  logic [1:0]      prm_lock;
  logic            prm_len_bad;
  logic            prm_id_bad;
  logic            prm_wd_bad;
  logic            prm_dly_bad;
  logic            prm_ok;
  logic [7:0]      cfg_exp;
  logic            cfg_bad;
  logic            cfg_mis;
  logic            cfg_fin;
  logic            bit_tick;

  assign apb_wr    = psel & penable & pwrite;
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~addr_known(paddr);
  assign prdata    = r_reg.prdata;
  assign mem_we    = apb_wr & (paddr == `FSC_OFF_CFGWR) & (int'(pwdata[12:8]) < MAX_MODS);
  // Next byte is refused while a verdict or reply is still pending
  assign rx_ready  = r_reg.enable & ~r_reg.busy & ~r_reg.cmp_v & ~r_reg.prm_end;
  assign rx_take   = rx.valid & rx_ready;
  assign rx_idx    = r_reg.open ? r_reg.cnt : 6'h00;
  // Byte 0 is the unit itself, so module k sits at byte k+1
  assign mem_raddr = AW'(rx_idx - 6'h01);
  assign bit_tick  = r_reg.busy & (int'(r_reg.bit_div) == BIT_CYC - 1);

  assign prm_id      = {r_reg.b[4], r_reg.b[5]};
  assign prm_lock    = {r_reg.b[0][`FSC_B0_LOCK], r_reg.b[0][`FSC_B0_UNLOCK]};
  // Bytes past the seventh are ignored up to a full frame
  assign prm_len_bad = (r_reg.cnt < `FSC_PRM_STD_LEN) | (r_reg.cnt > `FSC_PRM_MAX_LEN);
  assign prm_id_bad  = (prm_id != OWN_ID);
  assign prm_wd_bad  = (r_reg.b[1] == 8'h00) | (r_reg.b[2] == 8'h00);
  assign prm_dly_bad = (prm_lock == 2'b10) & (r_reg.b[3] == 8'h00);
  assign prm_ok      = ~(prm_len_bad | prm_id_bad | prm_wd_bad | prm_dly_bad);

  assign cfg_exp = (r_reg.cmp_idx == 6'h00) ? `FSC_ID_IU : mem_rdata;
  assign cfg_bad = (r_reg.cmp_byte != cfg_exp) | (r_reg.cmp_idx > {1'b0, r_reg.mod_cnt});
  assign cfg_mis = r_reg.mis | cfg_bad |
                   (r_reg.cmp_last & (r_reg.cmp_idx != {1'b0, r_reg.mod_cnt}));
  assign cfg_fin = r_reg.cmp_v & r_reg.cmp_last;

  fsc_cfg_mem #(
    .W     (8),
    .DEPTH (MAX_MODS),
    .AW    (AW)
  ) u_mem (
    .pclk  (pclk),
    .we    (mem_we),
    .waddr (AW'(pwdata[12:8])),
    .wdata (pwdata[7:0]),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  always_comb begin
    r_next         = r_reg;
    r_next.ack_v   = 1'b0;
    r_next.cmp_v   = 1'b0;
    r_next.prm_end = 1'b0;

    // Register bus: read data latched in the setup cycle, zero wait states
    if (psel & ~penable) begin
      case (paddr)
        `FSC_OFF_CTRL:   r_next.prdata = {31'h0, r_reg.enable};
        `FSC_OFF_STATUS: r_next.prdata = {23'h0, r_reg.locked, 1'b0, r_reg.prm_fault,
                                          3'h0, r_reg.cfg_fault, r_reg.st};
        `FSC_OFF_PARAM:  r_next.prdata = {r_reg.group, r_reg.delay, r_reg.f2, r_reg.f1};
        `FSC_OFF_WDPROD: r_next.prdata = {16'h0, r_reg.wdp};
        `FSC_OFF_MODCNT: r_next.prdata = {27'h0, r_reg.mod_cnt};
        `FSC_OFF_IOLEN:  r_next.prdata = {23'h0, r_reg.iolen};
        default:         r_next.prdata = 32'h0;
      endcase
    end
    if (apb_wr & (paddr == `FSC_OFF_CTRL)) begin
      r_next.enable = pwdata[0];
    end
    if (apb_wr & (paddr == `FSC_OFF_MODCNT) & (int'(pwdata[4:0]) <= MAX_MODS)) begin
      r_next.mod_cnt = pwdata[4:0];
    end

    // Watchdog runs only in data exchange; expiry asks for new parameters
    if (r_reg.st == FSC_DATA_EXCH) begin
      if (int'(r_reg.wd_div) == WD_UNIT_CYC - 1) begin
        r_next.wd_div = 20'h0;
        if ((r_reg.wd_cnt + 16'h1) >= r_reg.wdp) begin
          r_next.wd_cnt = 16'h0;
          r_next.st     = FSC_WAIT_PRM;
        end else begin
          r_next.wd_cnt = r_reg.wd_cnt + 16'h1;
        end
      end else begin
        r_next.wd_div = r_reg.wd_div + 20'h1;
      end
    end else begin
      r_next.wd_div = 20'h0;
      r_next.wd_cnt = 16'h0;
    end

    if (rx_take) begin
      r_next.open = ~rx.last;
      r_next.cnt  = (rx_idx == 6'h3F) ? rx_idx : rx_idx + 6'h01;
      if (rx_idx == 6'h00) begin
        r_next.mis = 1'b0;
        r_next.acc = 9'h000;
      end
      if (rx.cfg) begin
        r_next.cmp_v    = 1'b1;
        r_next.cmp_last = rx.last;
        r_next.cmp_byte = rx.data;
        r_next.cmp_idx  = rx_idx;
      end else begin
        if (rx_idx < `FSC_PRM_STD_LEN) begin
          r_next.b[rx_idx[2:0]] = rx.data;
        end
        r_next.prm_end = rx.last;
      end
    end

    if (r_reg.cmp_v) begin
      r_next.mis = cfg_mis;
      r_next.acc = r_reg.acc + id_units(r_reg.cmp_byte);
    end
    if (cfg_fin) begin
      r_next.busy    = 1'b1;
      r_next.dly     = r_reg.delay;
      r_next.ack_cfg = 1'b1;
      r_next.ok      = ~cfg_mis & (r_reg.st != FSC_WAIT_PRM);
      r_next.wd_div  = 20'h0;
      r_next.wd_cnt  = 16'h0;
      if (~cfg_mis & (r_reg.st != FSC_WAIT_PRM)) begin
        r_next.st        = FSC_DATA_EXCH;
        r_next.cfg_fault = 1'b0;
        r_next.iolen     = r_reg.acc + id_units(r_reg.cmp_byte);
      end else begin
        r_next.st        = FSC_WAIT_PRM;
        r_next.cfg_fault = 1'b1;
      end
    end

    if (r_reg.prm_end) begin
      r_next.busy    = 1'b1;
      r_next.dly     = r_reg.delay;
      r_next.ack_cfg = 1'b0;
      r_next.ok      = prm_ok;
      if (prm_ok) begin
        r_next.delay     = r_reg.b[3];
        r_next.prm_fault = 1'b0;
        r_next.st        = FSC_WAIT_CFG;
        // Lock 00 touches no parameter but the responder delay
        if (prm_lock != 2'b00) begin
          r_next.f1     = r_reg.b[1];
          r_next.f2     = r_reg.b[2];
          r_next.wdp    = wd_mult(r_reg.b[1], r_reg.b[2]);
          r_next.mode   = r_reg.b[0][5:0];
          r_next.locked = (prm_lock == 2'b10);
          if (r_reg.b[0][`FSC_B0_LOCK]) begin
            r_next.group = r_reg.b[6];
          end
        end
      end else begin
        r_next.prm_fault = 1'b1;
        r_next.st        = FSC_WAIT_PRM;
      end
    end

    // Reply is held back for the responder delay, counted in bit times
    if (r_reg.busy) begin
      r_next.bit_div = bit_tick ? 8'h00 : r_reg.bit_div + 8'h01;
      if (bit_tick) begin
        if (r_reg.dly == 8'h00) begin
          r_next.busy   = 1'b0;
          r_next.ack_v  = 1'b1;
          r_next.ack_ok = r_reg.ok;
        end else begin
          r_next.dly = r_reg.dly - 8'h01;
        end
      end
    end else begin
      r_next.bit_div = 8'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg         <= '0;
      r_reg.enable  <= `FSC_CTRL_RST;
      r_reg.mod_cnt <= `FSC_MODCNT_RST;
      r_reg.st      <= FSC_WAIT_PRM;
    end else begin
      r_reg <= r_next;
    end
  end

  assign ack              = '{valid: r_reg.ack_v, ok: r_reg.ack_ok, cfg: r_reg.ack_cfg};
  assign station_state    = r_reg.st;
  assign diag_cfg_fault   = r_reg.cfg_fault;
  assign diag_prm_fault   = r_reg.prm_fault;
  assign locked           = r_reg.locked;
  assign group_mask       = r_reg.group;
  assign responder_delay  = r_reg.delay;
  assign watchdog_product = r_reg.wdp;

  // Bit times elapsed since the verdict, for the reply gap check
  logic [8:0] gap_cnt;
  logic [7:0] gap_need;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_cnt  <= 9'h000;
      gap_need <= 8'h00;
    end else if (r_reg.prm_end | cfg_fin) begin
      gap_cnt  <= 9'h000;
      gap_need <= r_reg.delay;
    end else if (bit_tick & (gap_cnt != 9'h1FF)) begin
      gap_cnt <= gap_cnt + 9'h001;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_prm_done;
    r_reg.prm_end;
  endsequence
  sequence s_prm_good_lock(logic [1:0] lk);
    r_reg.prm_end && prm_ok && (prm_lock == lk);
  endsequence

  chk_ack_polarity: assert property (s_prm_done |=> r_reg.busy && (r_reg.ok == $past(prm_ok)))
    else $error("acknowledge polarity differs from parameter verdict");
  chk_wd_product: assert property (s_prm_done and ##0 prm_ok && prm_lock[0]
      |=> watchdog_product == ({8'h00, $past(r_reg.b[1])} * {8'h00, $past(r_reg.b[2])}))
    else $error("watchdog product not equal to factor product");
  chk_reply_gap: assert property (r_reg.ack_v |-> gap_cnt >= {1'b0, gap_need})
    else $error("reply sent before responder delay elapsed");
  chk_lock00_keep: assert property (s_prm_good_lock(2'b00)
      |=> $stable(r_reg.f1) && $stable(r_reg.f2) && $stable(group_mask)
          && responder_delay == $past(r_reg.b[3]))
    else $error("lock 00 changed more than responder delay");
  chk_id_reject: assert property (s_prm_done and ##0 prm_id_bad
      |=> diag_prm_fault && station_state == FSC_WAIT_PRM)
    else $error("wrong identity was accepted");
  chk_group_gate: assert property (s_prm_done and ##0 !r_reg.b[0][`FSC_B0_LOCK]
      |=> $stable(group_mask))
    else $error("group mask taken without lock bit");
  chk_lock10_set: assert property (s_prm_good_lock(2'b10) |=> locked)
    else $error("lock 10 did not lock the station");
  chk_unlock_set: assert property (s_prm_done and ##0 prm_ok && prm_lock[0] |=> !locked)
    else $error("unlock code left station locked");
  chk_wd_zero: assert property (s_prm_done and ##0 prm_wd_bad
      |=> !r_reg.ok && diag_prm_fault)
    else $error("zero watchdog factor not refused");
  chk_cfg_fail: assert property (cfg_fin && cfg_mis
      |=> station_state == FSC_WAIT_PRM && diag_cfg_fault && !r_reg.ok)
    else $error("configuration mismatch not handled");
  chk_ack_single: assert property (r_reg.ack_v |=> !r_reg.ack_v && !r_reg.busy)
    else $error("acknowledge longer than one cycle");

endmodule : fsc_param_cfg_check

// ==== rtl/fsc_defines.svh ====
// Register offsets, field positions, reset values and timing counts of the checker
`ifndef FSC_DEFINES_SVH
`define FSC_DEFINES_SVH

`define FSC_OFF_CTRL       12'h000
`define FSC_OFF_STATUS     12'h004
`define FSC_OFF_PARAM      12'h008
`define FSC_OFF_WDPROD     12'h00C
`define FSC_OFF_MODCNT     12'h010
`define FSC_OFF_CFGWR      12'h014
`define FSC_OFF_IOLEN      12'h018

`define FSC_ST_CFG_FAULT   2
`define FSC_ST_PRM_FAULT   6
`define FSC_ST_LOCKED      8

`define FSC_B0_LOCK        7
`define FSC_B0_UNLOCK      6

`define FSC_CTRL_RST       1'b1
`define FSC_MODCNT_RST     5'h00

`define FSC_PRM_STD_LEN    6'h07
`define FSC_PRM_MAX_LEN    6'h20

`define FSC_ID_IU          8'h70
`define FSC_ID_DIN16       8'h50
`define FSC_ID_DOUT16      8'h60
`define FSC_ID_AOUT4       8'h63
`define FSC_ID_AIN8        8'h57

`define FSC_CLK_HZ         50000000
`define FSC_WD_UNIT_MS     10
`define FSC_WD_UNIT_CYC    ((`FSC_CLK_HZ / 1000) * `FSC_WD_UNIT_MS)
`define FSC_BIT_CYC        4

`endif

// ==== rtl/fsc_pkg.sv ====
// Types shared by the parameter and configuration checker
package fsc_pkg;

  typedef enum logic [1:0] {
    FSC_WAIT_PRM  = 2'b00,
    FSC_WAIT_CFG  = 2'b01,
    FSC_DATA_EXCH = 2'b10
  } fsc_state_t;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic       cfg;
    logic [7:0] data;
  } fsc_rx_t;

  typedef struct packed {
    logic valid;
    logic ok;
    logic cfg;
  } fsc_ack_t;

endpackage : fsc_pkg

// ==== rtl/fsc_cfg_mem.sv ====
// Local module identifier store with registered read port
`timescale 1ns/1ps
module fsc_cfg_mem #(
  parameter int W     = 8,
  parameter int DEPTH = 8,
  parameter int AW    = 3
)(
  input  wire logic          pclk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);

  if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_depth
    $error("fsc_cfg_mem: depth does not fit address width");
  end

  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule : fsc_cfg_mem

// ==== sim/fsc_master_model.sv ====
// Behavioural fieldbus master that feeds frames to the checker
`timescale 1ns/1ps
module fsc_master_model
  import fsc_pkg::*;
(
  input  wire logic     pclk,
  output fsc_rx_t       rx,
  input  wire logic     rx_ready,
  input  wire fsc_ack_t ack
);
  initial rx = '0;

  // Idle data is inverted so a stale byte is never mistaken for a fresh one
  task automatic send(input logic [7:0] b[32], input int n, input logic c,
                      output logic [1:0] r, output int lat);
    int   k;
    logic t;
    lat = -1;
    r   = 2'b00;
    @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      rx <= '{1'b1, (i == n - 1), c, b[i]};
      for (k = 0; k < 300; k++) begin
        @(negedge pclk);
        t = rx_ready;
        @(posedge pclk);
        if (t) break;
      end
      if (k == 300) return;
    end
    rx <= '{1'b0, 1'b0, c, ~b[n-1]};
    for (k = 1; k < 2000; k++) begin
      @(negedge pclk);
      if (ack.valid === 1'b1) begin
        r   = {ack.cfg, ack.ok};
        lat = k;
        break;
      end
    end
  endtask : send
endmodule : fsc_master_model

// ==== sim/tb_fsc_param_cfg_check.sv ====
// Self-checking bench for the parameter and configuration checker
`timescale 1ns/1ps
module tb_fsc_param_cfg_check
  import fsc_pkg::*;
;
  localparam logic [15:0] ID_T = 16'h1234; // Arbitrary identity value
  localparam int          BC   = 4;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        rx_ready, cf, pf, locked;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0]  group_mask, responder_delay;
  logic [15:0] watchdog_product;
  fsc_rx_t     rx;
  fsc_ack_t    ack;
  fsc_state_t  station_state;
  int          bad_count, total_checks;

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  fsc_param_cfg_check #(.OWN_ID(ID_T), .WD_UNIT_CYC(10), .BIT_CYC(BC)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx(rx), .rx_ready(rx_ready),
    .ack(ack), .station_state(station_state), .diag_cfg_fault(cf),
    .diag_prm_fault(pf), .locked(locked), .group_mask(group_mask),
    .responder_delay(responder_delay), .watchdog_product(watchdog_product));

  fsc_master_model mst (.pclk(pclk), .rx(rx), .rx_ready(rx_ready), .ack(ack));

  task automatic stop_test();
    if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : cmp

  // Request held until pready is sampled high at a falling edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic err);
    int   k;
    logic t;
    // One idle edge between transfers keeps psel to one assignment per step
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(negedge pclk);
      t   = pready;
      q   = prdata;
      err = pslverr;
      @(posedge pclk);
      if (t === 1'b1) break;
    end
    if (k == 50) begin
      bad_count++;
      stop_test();
    end else begin
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic e;
    apb(1'b1, a, d, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic e;
    apb(1'b0, a, 32'h0, e);
    cmp("prdata", x, q);
    cmp("pslverr", {31'h0, xe}, {31'h0, e});
  endtask : rd

  task automatic frame(input logic [7:0] b[32], input int n, input logic c,
                       input logic eok, input int mlat);
    logic [1:0] r;
    int         lat;
    mst.send(b, n, c, r, lat);
    cmp("ack", {30'h0, c, eok}, {30'h0, r});
    cmp("reply_gap", 32'h1, {31'h0, lat >= mlat});
    // A frame that never got through or never got answered ends the run
    if (lat < 0) stop_test();
  endtask : frame

  task automatic prm(input logic [7:0] b0, f1, f2, d, input logic [15:0] id,
                     input logic [7:0] g, input int n, input logic eok, input int ml);
    logic [7:0] b[32];
    foreach (b[i]) b[i] = 8'hEE;
    b[0] = b0;
    b[1] = f1;
    b[2] = f2;
    b[3] = d;
    b[4] = id[15:8];
    b[5] = id[7:0];
    b[6] = g;
    frame(b, n, 1'b0, eok, ml);
  endtask : prm

  task automatic cfg3(input logic [7:0] x, y, z, input logic eok, input int ml);
    logic [7:0] b[32];
    foreach (b[i]) b[i] = 8'h00;
    b[0] = x;
    b[1] = y;
    b[2] = z;
    frame(b, 3, 1'b1, eok, ml);
  endtask : cfg3

  task automatic st(input logic [1:0] s, input logic c, p, l);
    cmp("status", {27'h0, s, c, p, l}, {27'h0, station_state, cf, pf, locked});
  endtask : st

  task automatic t_reset();
    st(2'h0, 1'b0, 1'b0, 1'b0);
    rd(12'h000, 32'h1, 1'b0);
    rd(12'h010, 32'h0, 1'b0);
    rd(12'h004, 32'h0, 1'b0);
    rd(12'hFFC, 32'h0, 1'b1);
    wr(12'h000, 32'h0);
    @(negedge pclk);
    cmp("rx_ready_off", 32'h0, {31'h0, rx_ready});
    wr(12'h000, 32'h1);
    wr(12'h010, 32'h9);
    rd(12'h010, 32'h0, 1'b0);
    wr(12'h010, 32'h2);
    wr(12'h014, 32'h0050);
    wr(12'h014, 32'h0163);
  endtask : t_reset

  task automatic t_param_faults();
    prm(8'h80, 8'h03, 8'h05, 8'h02, ID_T ^ 16'h0100, 8'h00, 7, 1'b0, BC + 1);
    st(2'h0, 1'b0, 1'b1, 1'b0);
    prm(8'h80, 8'h00, 8'h05, 8'h02, ID_T, 8'h00, 7, 1'b0, BC + 1);
    prm(8'h80, 8'h03, 8'h00, 8'h02, ID_T, 8'h00, 7, 1'b0, BC + 1);
    prm(8'h80, 8'h03, 8'h05, 8'h00, ID_T, 8'h00, 7, 1'b0, BC + 1);
    prm(8'h80, 8'h03, 8'h05, 8'h02, ID_T, 8'h00, 6, 1'b0, BC + 1);
    cfg3(8'h70, 8'h50, 8'h63, 1'b0, BC + 1);
    st(2'h0, 1'b1, 1'b1, 1'b0);
  endtask : t_param_faults

  task automatic t_param_good();
    prm(8'h80, 8'h03, 8'h05, 8'h02, ID_T, 8'hA5, 10, 1'b1, BC + 1);
    st(2'h1, 1'b1, 1'b0, 1'b1);
    cmp("group_mask", 32'hA5, {24'h0, group_mask});
    cmp("watchdog", 32'd15, {16'h0, watchdog_product});
    rd(12'h008, 32'hA5020503, 1'b0);
    rd(12'h00C, 32'd15, 1'b0);
    prm(8'hC0, 8'h03, 8'h05, 8'h02, ID_T, 8'h3C, 7, 1'b1, 3 * BC + 1);
    st(2'h1, 1'b1, 1'b0, 1'b0);
    cmp("group_mask", 32'h3C, {24'h0, group_mask});
  endtask : t_param_good

  task automatic t_cfg();
    cfg3(8'h70, 8'h50, 8'h60, 1'b0, 3 * BC + 1);
    st(2'h0, 1'b1, 1'b0, 1'b0);
    prm(8'h40, 8'h03, 8'h05, 8'h02, ID_T, 8'h0F, 7, 1'b1, 3 * BC + 1);
    cmp("group_mask", 32'h3C, {24'h0, group_mask});
    prm(8'h00, 8'h09, 8'h09, 8'h07, ID_T, 8'h00, 7, 1'b1, 3 * BC + 1);
    cmp("delay", 32'h07, {24'h0, responder_delay});
    cmp("watchdog", 32'd15, {16'h0, watchdog_product});
    cmp("group_mask", 32'h3C, {24'h0, group_mask});
    cfg3(8'h70, 8'h50, 8'h63, 1'b1, 8 * BC + 1);
    st(2'h2, 1'b0, 1'b0, 1'b0);
    rd(12'h018, 32'd6, 1'b0);
  endtask : t_cfg

  // Expiry is 150 cycles after the verdict with factors 3 and 5
  task automatic t_watchdog();
    int k;
    // State is sampled mid-cycle, away from the edge that updates it
    repeat (90) @(negedge pclk);
    st(2'h2, 1'b0, 1'b0, 1'b0);
    for (k = 0; k < 200; k++) begin
      @(negedge pclk);
      if (station_state === FSC_WAIT_PRM) break;
    end
    cmp("wd_expiry", 32'h1, {31'h0, k < 200});
  endtask : t_watchdog

  initial begin
    #2000000;
    bad_count++;
    stop_test();
  end

  initial begin
    bad_count    = 0;
    total_checks = 0;
    presetn      = 1'b0;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = 12'h000;
    pwdata       = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_param_faults();
    t_param_good();
    t_cfg();
    t_watchdog();
    stop_test();
  end
endmodule : tb_fsc_param_cfg_check
